// ===== hdl/lpsdram_pkg.sv
// Shared constants and types for the low-power DRAM die and its controller.
`default_nettype none
package lpsdram_pkg;
  typedef logic [15:0] cnt_t;
  typedef logic [3:0]  cmd_t;
  typedef logic [1:0]  bank_t;
  typedef logic [13:0] row_t;

  // ---------------------------------------------------------------------
  // Timing, in nanoseconds at a 5 ns system clock
  // ---------------------------------------------------------------------
  localparam int CLK_PS    = 5000;
  localparam int T_WR_NS   = 15;
  localparam int T_RP_NS   = 18;
  localparam int T_RCD_NS  = 18;
  localparam int T_RFC_NS  = 72;
  localparam int T_MRD_NS  = 10;
  localparam int T_CKE_NS  = 10;
  localparam int T_PDEX_NS = 10;
  localparam int T_REF_NS  = 7800;
  localparam int T_INIT_US = 200;

  localparam cnt_t C_WR   = cnt_t'((T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_RP   = cnt_t'((T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_RCD  = cnt_t'((T_RCD_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_RFC  = cnt_t'((T_RFC_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_MRD  = cnt_t'((T_MRD_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_CKE  = cnt_t'((T_CKE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_PDEX = cnt_t'((T_PDEX_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam cnt_t C_REF  = cnt_t'(T_REF_NS * 1000 / CLK_PS);
  localparam int   C_INIT = (T_INIT_US * 1000000 + CLK_PS - 1) / CLK_PS;

  // Link clock half period in system cycles, and exit spacing in link cycles.
  localparam cnt_t       CK_HALF     = 16'h0004;
  localparam logic [3:0] NOP_EXIT_CK = 4'h2;
  // Power down ends early enough that the late exit slot still fits.
  localparam cnt_t C_PDN_MAX = cnt_t'(C_REF - 2 * CK_HALF);

  // ---------------------------------------------------------------------
  // Command encodings as {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------------
  localparam cmd_t CMD_MRS   = 4'h0;
  localparam cmd_t CMD_REF   = 4'h1;
  localparam cmd_t CMD_PRE   = 4'h2;
  localparam cmd_t CMD_ACT   = 4'h3;
  localparam cmd_t CMD_WR    = 4'h4;
  localparam cmd_t CMD_NOP   = 4'h7;
  localparam cmd_t CMD_DESEL = 4'h8;

  localparam int    AP_BIT   = 10;
  localparam row_t  AP_ALL   = 14'h0400;
  localparam row_t  ROW_ZERO = 14'h0000;
  localparam bank_t BA_MRS   = 2'h0;
  localparam bank_t BA_EMRS  = 2'h2;
  localparam row_t  MR_VALUE = 14'h0000;
  localparam row_t  EMR_VALUE = 14'h0000;

  typedef enum logic [2:0] {
    OP_ACT, OP_WRITE, OP_PRE, OP_REF, OP_SREF, OP_PDN, OP_CSTOP, OP_WAKE
  } op_e;
endpackage
`default_nettype wire

// ===== hdl/lpsdram_link.sv
// Command, address and clock pins between controller and DRAM die.
`default_nettype none
interface lpsdram_link;
  import lpsdram_pkg::*;
  logic  ck;
  logic  ck_n;
  logic  cke;
  logic  cs_n;
  logic  ras_n;
  logic  cas_n;
  logic  we_n;
  bank_t ba;
  row_t  addr;

  modport ctrl (output ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
  modport die  (input  ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface
`default_nettype wire

// ===== hdl/lpsdram_die_end.sv
// DRAM die end: command decode, write auto precharge, refresh, power down.
`default_nettype none
module lpsdram_die_end (
  input  wire logic        clk,
  input  wire logic        arst_n,
  lpsdram_link.die         link,
  output logic [3:0]       bank_open,
  output logic             ap_busy,
  output logic             auto_refreshing,
  output logic             self_refreshing,
  output logic             powered_down,
  output logic             rx_enabled,
  output logic             array_clk_en,
  output logic [13:0]      refresh_row,
  output logic [13:0]      mode_reg,
  output logic [13:0]      ext_mode_reg,
  output logic [1:0]       mode_valid
);
  import lpsdram_pkg::*;

  typedef enum {D_IDLE, D_AREF, D_SREF, D_PDN} die_state_e;
  typedef enum {AP_OFF, AP_WR, AP_PRE} ap_state_e;

  // -----------------------------------------------------------------------
  // Pin synchroniser
  // -----------------------------------------------------------------------
  logic [21:0] s1;
  logic [21:0] s2;
  logic        ck_prev;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1      <= 22'h170000;
      s2      <= 22'h170000;
      ck_prev <= 1'b0;
    end else begin
      s1      <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n,
                  link.we_n, link.ba, link.addr};
      s2      <= s1;
      ck_prev <= s2[21];
    end
  end

  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  die_state_e dstate;
  die_state_e next_dstate;
  ap_state_e  apstate;
  cnt_t       ap_cnt;
  cnt_t       rf_cnt;
  bank_t      ap_bank;
  wire        ck_edge  = s2[21] & ~ck_prev;
  wire        cke_s    = s2[20];
  wire cmd_t  cmd      = s2[19:16];
  wire bank_t ba_s     = s2[15:14];
  wire row_t  addr_s   = s2[13:0];
  wire        idle_e   = ck_edge & (dstate == D_IDLE);
  wire        run_e    = idle_e & cke_s;
  wire        do_act   = run_e & (cmd == CMD_ACT);
  wire        do_pre   = run_e & (cmd == CMD_PRE);
  wire        do_wr    = run_e & (cmd == CMD_WR);
  wire        do_wrap  = do_wr & addr_s[AP_BIT];
  wire        do_aref  = run_e & (cmd == CMD_REF);
  wire        do_mrs   = run_e & (cmd == CMD_MRS);
  wire        do_sref  = idle_e & ~cke_s & (cmd == CMD_REF);
  wire        do_pdn   = idle_e & ~cke_s & (cmd != CMD_REF);
  wire        ap_done  = (apstate == AP_PRE) & (ap_cnt == 16'h0000);
  wire        sr_step  = (dstate == D_SREF) & (rf_cnt == 16'h0000);

  always_comb begin
    next_dstate = dstate;
    case (dstate)
      D_IDLE: begin
        if (do_aref) next_dstate = D_AREF;
        else if (do_sref) next_dstate = D_SREF;
        else if (do_pdn) next_dstate = D_PDN;
      end
      D_AREF:  if (rf_cnt == 16'h0000) next_dstate = D_IDLE;
      D_SREF:  if (cke_s) next_dstate = D_IDLE;
      D_PDN:   if (cke_s) next_dstate = D_IDLE;
      default: next_dstate = D_IDLE;
    endcase
  end

  // -----------------------------------------------------------------------
  // Mode state, refresh timing and low-power flags
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dstate          <= D_IDLE;
      rf_cnt          <= 16'h0000;
      refresh_row     <= 14'h0000;
      auto_refreshing <= 1'b0;
      self_refreshing <= 1'b0;
      powered_down    <= 1'b0;
      rx_enabled      <= 1'b1;
      array_clk_en    <= 1'b1;
    end else begin
      dstate          <= next_dstate;
      auto_refreshing <= next_dstate == D_AREF;
      self_refreshing <= next_dstate == D_SREF;
      powered_down    <= next_dstate == D_PDN;
      rx_enabled      <= next_dstate != D_PDN;
      array_clk_en    <= next_dstate != D_SREF;
      if (rf_cnt != 16'h0000) rf_cnt <= rf_cnt - 1'b1;
      // One short, so a refresh spaced exactly tRFC behind is still taken.
      if (do_aref) rf_cnt <= C_RFC - 16'h0001;
      if (do_sref | sr_step) rf_cnt <= C_REF;
      if (do_aref | sr_step) refresh_row <= refresh_row + 1'b1;
    end
  end

  // Only one write auto precharge is tracked; the controller's spacing
  // keeps the next one clear of it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apstate <= AP_OFF;
      ap_cnt  <= 16'h0000;
      ap_bank <= 2'h0;
      ap_busy <= 1'b0;
    end else begin
      if (ap_cnt != 16'h0000) ap_cnt <= ap_cnt - 1'b1;
      case (apstate)
        AP_OFF: if (do_wrap) begin
          apstate <= AP_WR;
          ap_cnt  <= C_WR - 16'h0001;
          ap_bank <= ba_s;
          ap_busy <= 1'b1;
        end
        AP_WR: if (ap_cnt == 16'h0000) begin
          apstate <= AP_PRE;
          ap_cnt  <= C_RP - 16'h0001;
        end
        AP_PRE: if (ap_done) begin
          apstate <= AP_OFF;
          ap_busy <= 1'b0;
        end
        default: apstate <= AP_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_open <= 4'h0;
    end else begin
      if (ap_done) bank_open[ap_bank] <= 1'b0;
      if (do_act) bank_open[ba_s] <= 1'b1;
      if (do_pre & addr_s[AP_BIT]) bank_open <= 4'h0;
      else if (do_pre) bank_open[ba_s] <= 1'b0;
      if (dstate == D_AREF) bank_open <= 4'h0;
    end
  end

  // Values are cleared only to keep outputs defined; they mean nothing
  // until the matching valid bit is set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg     <= 14'h0000;
      ext_mode_reg <= 14'h0000;
      mode_valid   <= 2'h0;
    end else if (do_mrs & (ba_s == BA_MRS)) begin
      mode_reg      <= addr_s;
      mode_valid[0] <= 1'b1;
    end else if (do_mrs & (ba_s == BA_EMRS)) begin
      ext_mode_reg  <= addr_s;
      mode_valid[1] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/lpsdram_ctrl_end.sv
// Controller end: link clock, power-up sequence and timed command issue.
// Summary of operation
// - Write with address bit ten precharges bank
// - Precharge after write recovery; bank then untouched
// - Activate only after precharge period elapsed
// - Refresh decoded from pins with clock enable
// - Refresh only when all banks idle
// - Refresh uses internal rows, leaves banks idle
// - Wait refresh cycle time after refresh
// - Self refresh decoded with clock enable low
// - Clock enable held low during self refresh
// - Clock may stop one cycle after entry
// - Die gates internal clock, self refreshes
// - Stable clock and no-ops before exit
// - Self refresh idle entry, minimum refresh time
// - Power down follows clock enable level
// - Idle banks; exit lead before activate
// - Power down ends within refresh interval
// - Power down lasts minimum, idle entry
// - Clock stop when idle, timed, enabled; stop is issued without checking banks idle
// - One no-op after clock restart
// - Power-up wait with no-ops, enable high
// - Precharge, two refreshes, mode, extended mode
// - Mode registers undefined until programmed
// - Mode writes only with banks idle
// - No bank reuse until precharge time
`default_nettype none
module lpsdram_ctrl_end #(
  parameter int INIT_CYCLES = lpsdram_pkg::C_INIT
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  lpsdram_link.ctrl               link,
  input  wire logic               req,
  input  wire lpsdram_pkg::op_e   req_op,
  input  wire lpsdram_pkg::bank_t req_bank,
  input  wire lpsdram_pkg::row_t  req_row,
  input  wire logic               req_ap,
  output logic                    ready,
  output logic                    req_err,
  output logic                    init_done,
  output logic [3:0]              bank_open
);
  import lpsdram_pkg::*;

  typedef enum {
    C_PWRUP, C_IPRE, C_IREF, C_IMRS, C_IEMRS,
    C_RUN, C_SREF, C_PDN, C_CSTOP, C_WAKE
  } cst_e;

  cst_e       state;
  logic       ck;
  logic       ck_n;
  logic       cke;
  logic       ck_run;
  cnt_t       div;
  cmd_t       cmd;
  bank_t      ba;
  row_t       addr;
  cnt_t       wait_cnt;
  cnt_t       pdn_cnt;
  logic [1:0] ref_left;
  logic [3:0] nop_left;
  logic       pend;
  op_e        p_op;
  bank_t      p_bank;
  row_t       p_row;
  logic       p_ap;

  assign link.ck    = ck;
  assign link.ck_n  = ck_n;
  assign link.cke   = cke;
  assign link.cs_n  = cmd[3];
  assign link.ras_n = cmd[2];
  assign link.cas_n = cmd[1];
  assign link.we_n  = cmd[0];
  assign link.ba    = ba;
  assign link.addr  = addr;

  // -----------------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------------
  // Pins change only as the link clock falls, so the die sees them settled.
  wire slot      = ck_run & ck & (div == CK_HALF - 1'b1);
  wire waited    = wait_cnt == 16'h0000;
  wire all_idle  = bank_open == 4'h0;
  wire low_state = (state == C_SREF) | (state == C_PDN) | (state == C_CSTOP);
  wire take      = req & ready;
  wire need_idle = (p_op == OP_REF) | (p_op == OP_SREF) | (p_op == OP_PDN);
  wire legal     = ~(need_idle & ~all_idle) & (p_op != OP_WAKE);
  wire issue     = slot & waited & pend & (state == C_RUN);
  wire drop      = pend & low_state & (p_op != OP_WAKE);
  wire wake_stop = pend & waited & (p_op == OP_WAKE) & low_state & ~ck_run;
  wire pdn_exit  = slot & (state == C_PDN) & ((pend & waited &
                   (p_op == OP_WAKE)) | (pdn_cnt == 16'h0000));
  wire pend_clr  = issue | drop | wake_stop | (pdn_exit & pend);
  wire op_act    = issue & legal & (p_op == OP_ACT);
  wire op_wr     = issue & legal & (p_op == OP_WRITE);
  wire op_pre    = issue & legal & (p_op == OP_PRE);

  // -----------------------------------------------------------------------
  // Link clock divider
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div  <= 16'h0000;
      ck   <= 1'b0;
      ck_n <= 1'b1;
    end else if (!ck_run) begin
      div  <= 16'h0000;
      ck   <= 1'b0;
      ck_n <= 1'b1;
    end else if (div == CK_HALF - 1'b1) begin
      div  <= 16'h0000;
      ck   <= ~ck;
      ck_n <= ck;
    end else begin
      div  <= div + 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Request holding
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend   <= 1'b0;
      p_op   <= OP_ACT;
      p_bank <= 2'h0;
      p_row  <= 14'h0000;
      p_ap   <= 1'b0;
      ready  <= 1'b0;
    end else begin
      ready <= ((state == C_RUN) | low_state) & ~pend & ~take & waited;
      if (take) begin
        pend   <= 1'b1;
        p_op   <= req_op;
        p_bank <= req_bank;
        p_row  <= req_row;
        p_ap   <= req_ap;
      end else if (pend_clr) begin
        pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_open <= 4'h0;
      req_err   <= 1'b0;
    end else begin
      req_err <= drop | (issue & ~legal);
      if (op_act) bank_open[p_bank] <= 1'b1;
      if (op_wr & p_ap) bank_open[p_bank] <= 1'b0;
      if (op_pre & p_ap) bank_open <= 4'h0;
      else if (op_pre) bank_open[p_bank] <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= C_PWRUP;
      cke       <= 1'b1;
      ck_run    <= 1'b1;
      cmd       <= CMD_NOP;
      ba        <= 2'h0;
      addr      <= 14'h0000;
      wait_cnt  <= cnt_t'(INIT_CYCLES);
      pdn_cnt   <= 16'h0000;
      ref_left  <= 2'h2;
      nop_left  <= 4'h0;
      init_done <= 1'b0;
    end else begin
      if (!waited) wait_cnt <= wait_cnt - 1'b1;
      if (pdn_cnt != 16'h0000) pdn_cnt <= pdn_cnt - 1'b1;
      if (slot) cmd <= CMD_NOP;
      case (state)
        C_PWRUP: if (slot & waited) begin
          cmd      <= CMD_PRE;
          addr     <= AP_ALL;
          wait_cnt <= C_RP;
          state    <= C_IPRE;
        end
        C_IPRE, C_IREF: if (slot & waited) begin
          if (ref_left != 2'h0) begin
            cmd      <= CMD_REF;
            wait_cnt <= C_RFC;
            ref_left <= ref_left - 1'b1;
            state    <= C_IREF;
          end else begin
            cmd      <= CMD_MRS;
            ba       <= BA_MRS;
            addr     <= MR_VALUE;
            wait_cnt <= C_MRD;
            state    <= C_IMRS;
          end
        end
        C_IMRS: if (slot & waited) begin
          cmd      <= CMD_MRS;
          ba       <= BA_EMRS;
          addr     <= EMR_VALUE;
          wait_cnt <= C_MRD;
          state    <= C_IEMRS;
        end
        C_IEMRS: if (waited) begin
          init_done <= 1'b1;
          state     <= C_RUN;
        end
        C_RUN: if (issue & legal) begin
          case (p_op)
            OP_ACT: begin
              cmd      <= CMD_ACT;
              ba       <= p_bank;
              addr     <= p_row;
              wait_cnt <= C_RCD;
            end
            OP_WRITE: begin
              cmd      <= CMD_WR;
              ba       <= p_bank;
              addr     <= p_ap ? AP_ALL : ROW_ZERO;
              wait_cnt <= p_ap ? C_WR + C_RP : C_WR;
            end
            OP_PRE: begin
              cmd      <= CMD_PRE;
              ba       <= p_bank;
              addr     <= p_ap ? AP_ALL : ROW_ZERO;
              wait_cnt <= C_RP;
            end
            OP_REF: begin
              cmd      <= CMD_REF;
              wait_cnt <= C_RFC;
            end
            OP_SREF: begin
              cmd      <= CMD_REF;
              cke      <= 1'b0;
              wait_cnt <= C_RFC;
              state    <= C_SREF;
            end
            OP_PDN: begin
              cke      <= 1'b0;
              wait_cnt <= C_CKE;
              pdn_cnt  <= C_PDN_MAX;
              state    <= C_PDN;
            end
            OP_CSTOP: begin
              ck_run <= 1'b0;
              state  <= C_CSTOP;
            end
            default: state <= C_RUN;
          endcase
        end
        C_SREF, C_CSTOP: begin
          if (slot) ck_run <= 1'b0;
          if (wake_stop) begin
            ck_run   <= 1'b1;
            nop_left <= NOP_EXIT_CK;
            state    <= C_WAKE;
          end
        end
        C_PDN: if (pdn_exit) begin
          cke      <= 1'b1;
          wait_cnt <= C_PDEX;
          state    <= C_RUN;
        end
        C_WAKE: if (slot) begin
          if (nop_left != 4'h0) begin
            nop_left <= nop_left - 1'b1;
          end else begin
            if (!cke) begin
              cke      <= 1'b1;
              wait_cnt <= C_RFC;
            end
            state <= C_RUN;
          end
        end
        default: state <= C_RUN;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/lpsdram_asserts.sv
// Checker of the command pins that join the controller and the die.
`default_nettype none
module lpsdram_asserts #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic               clk,
  input wire logic               arst_n,
  input wire logic               ck,
  input wire logic               ck_n,
  input wire logic               cke,
  input wire logic               cs_n,
  input wire logic               ras_n,
  input wire logic               cas_n,
  input wire logic               we_n,
  input wire lpsdram_pkg::bank_t ba,
  input wire lpsdram_pkg::row_t  addr
);
  import lpsdram_pkg::*;
  // ---------------------------------------------------------------
  // Decode at the link clock rise, as the die sees it
  // ---------------------------------------------------------------
  logic       ck_q, sref, seen, mode_ok;
  logic [1:0] refs;
  logic [3:0] opn;
  cnt_t       lo_cnt, hi_cnt, ckl_cnt, rfc_cnt, wap_cnt, up_cnt;
  wire cmd_t  cmd    = {cs_n, ras_n, cas_n, we_n};
  wire logic  ck_up  = ck & ~ck_q;
  wire logic  idle   = cs_n | (cmd == CMD_NOP);
  wire logic  is_act = ck_up & (cmd == CMD_ACT);
  wire logic  is_ref = ck_up & (cmd == CMD_REF);
  wire logic  is_mrs = ck_up & (cmd == CMD_MRS);
  wire logic  is_pre = ck_up & (cmd == CMD_PRE);
  wire logic  is_wap = ck_up & (cmd == CMD_WR) & addr[AP_BIT];
  wire logic  first  = ck_up & ~idle & ~seen;
  wire logic [3:0] ba_dec = 4'h1 << ba;
  wire logic [3:0] next_opn = is_act ? (opn | ba_dec) :
                   (is_pre & addr[AP_BIT]) ? 4'h0 :
                   (is_pre | is_wap) ? (opn & ~ba_dec) : opn;

  function automatic cnt_t inc(input cnt_t v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {ck_q, sref, seen, mode_ok, refs, opn} <= '0;
    end else begin
      ck_q <= ck;
      opn <= next_opn;
      sref <= (is_ref | sref) & ~cke;
      seen <= seen | first;
      mode_ok <= mode_ok | (is_mrs & (ba == BA_MRS));
      refs <= (is_ref && refs != 2'h3) ? refs + 2'h1 : refs;
    end
  end

  // Counters saturate so that a long idle stretch never wraps to zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {lo_cnt, hi_cnt, ckl_cnt, up_cnt} <= '0;
      {rfc_cnt, wap_cnt} <= '1;
    end else begin
      lo_cnt <= cke ? '0 : inc(lo_cnt);
      hi_cnt <= cke ? inc(hi_cnt) : '0;
      ckl_cnt <= ck ? '0 : inc(ckl_cnt);
      rfc_cnt <= is_ref ? '0 : inc(rfc_cnt);
      wap_cnt <= is_wap ? '0 : inc(wap_cnt);
      up_cnt <= inc(up_cnt);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  clock_pair_a: assert property (ck_n == ~ck)
    else $error("link clock pair not complementary");
  pins_held_a: assert property (ck_up |-> ##1 $stable(cmd) [*2])
    else $error("command changed near sampling edge");
  ref_idle_a: assert property (is_ref |-> opn == 4'h0)
    else $error("refresh with an open bank");
  rfc_gap_a: assert property ((is_ref | is_act) |-> rfc_cnt + 1 >= C_RFC)
    else $error("refresh cycle time cut short");
  wap_gap_a: assert property ((is_act | is_ref) |->
    wap_cnt + 1 >= C_WR + C_RP)
    else $error("bank reused during auto precharge");
  low_min_a: assert property ($rose(cke) |->
    lo_cnt >= (sref ? C_RFC : C_CKE))
    else $error("low power period too short");
  pdn_max_a: assert property (!cke && !sref |-> lo_cnt <= C_REF)
    else $error("power down beyond refresh interval");
  exit_nop_a: assert property ($rose(cke) |->
    ckl_cnt <= 2 * CK_HALF && idle ##1 idle [*2])
    else $error("exit without running clock and no-ops");
  pdex_a: assert property (is_act |-> hi_cnt >= C_PDEX)
    else $error("activate too soon after power down exit");
  cstop_nop_a: assert property (ck_up && ckl_cnt > 2 * CK_HALF |-> idle)
    else $error("access command on first restarted clock");
  init_first_a: assert property (first |-> cmd == CMD_PRE &&
    addr[AP_BIT] && up_cnt >= INIT_CYCLES)
    else $error("initialisation did not open with precharge all");
  mrs_order_a: assert property (is_mrs |-> refs >= 2'h2 && opn == 4'h0)
    else $error("mode write before refreshes or with open bank");
  emr_after_a: assert property (is_mrs && ba == BA_EMRS |-> mode_ok)
    else $error("extended mode written before mode");

  cover property (is_wap);
  cover property (is_ref && !cke);
  cover property ($rose(cke) && !sref);
  cover property (ck_up && ckl_cnt > 2 * CK_HALF);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Bench joining controller and die ends and driving the request side.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import lpsdram_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req = 1'b0;
  logic        req_ap = 1'b0;
  op_e         req_op = OP_ACT;
  bank_t       req_bank = 2'h0;
  row_t        req_row = 14'h0000;
  logic        err_seen = 1'b0;
  logic        ap_seen = 1'b0;
  logic        ar_seen = 1'b0;
  logic        ready, req_err, init_done, ap_busy, auto_refreshing;
  logic        self_refreshing, powered_down, rx_enabled, array_clk_en;
  logic [3:0]  ctl_open, die_open;
  logic [1:0]  mode_valid;
  row_t        refresh_row, mode_reg, ext_mode_reg, r0;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          hi;
  lpsdram_link link_if ();

  lpsdram_ctrl_end #(.INIT_CYCLES(20)) i_lpsdram_ctrl_end (
    .clk(clk), .arst_n(arst_n), .link(link_if.ctrl), .req(req),
    .req_op(req_op), .req_bank(req_bank), .req_row(req_row),
    .req_ap(req_ap), .ready(ready), .req_err(req_err),
    .init_done(init_done), .bank_open(ctl_open));
  lpsdram_die_end i_lpsdram_die_end (
    .clk(clk), .arst_n(arst_n), .link(link_if.die),
    .bank_open(die_open), .ap_busy(ap_busy),
    .auto_refreshing(auto_refreshing), .self_refreshing(self_refreshing),
    .powered_down(powered_down), .rx_enabled(rx_enabled),
    .array_clk_en(array_clk_en), .refresh_row(refresh_row),
    .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
    .mode_valid(mode_valid));
  lpsdram_asserts #(.INIT_CYCLES(20)) i_lpsdram_asserts (
    .clk(clk), .arst_n(arst_n), .ck(link_if.ck), .ck_n(link_if.ck_n),
    .cke(link_if.cke), .cs_n(link_if.cs_n), .ras_n(link_if.ras_n),
    .cas_n(link_if.cas_n), .we_n(link_if.we_n), .ba(link_if.ba),
    .addr(link_if.addr));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (req_err === 1'b1) err_seen <= 1'b1;
    if (ap_busy === 1'b1) ap_seen <= 1'b1;
    if (auto_refreshing === 1'b1) ar_seen <= 1'b1;
  end

  // The whole sequence needs about 540 cycles; this cuts a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Requests are raised at a falling edge and held over the taking edge.
  task automatic op(input op_e o, input bank_t b, input row_t r,
                    input logic ap, input logic err);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    err_seen = 1'b0;
    req = 1'b1;
    req_op = o;
    req_bank = b;
    req_row = r;
    req_ap = ap;
    @(negedge clk);
    req = 1'b0;
    repeat (2) @(negedge clk);
    k = 0;
    while (ready !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) error_cnt++;
    repeat (12) @(negedge clk);
    chk(16'(err_seen), 16'(err));
  endtask

  task automatic stopped();
    hi = 0;
    repeat (24) begin
      @(negedge clk);
      if (link_if.ck !== 1'b0 || link_if.ck_n !== 1'b1) hi++;
    end
    chk(16'(hi), 16'h0000);
  endtask

  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    op(OP_ACT, 2'h1, 14'h0123, 1'b0, 1'b0);
    chk(16'(init_done), 16'h0001);
    chk(16'(mode_valid), 16'h0003);
    chk(16'(mode_reg), 16'(MR_VALUE));
    chk(16'(ext_mode_reg), 16'(EMR_VALUE));
    chk(16'(die_open), 16'h0002);
    chk(16'(ctl_open), 16'h0002);
    op(OP_WRITE, 2'h1, AP_ALL, 1'b1, 1'b0);
    chk(16'(ap_seen), 16'h0001);
    chk(16'(die_open), 16'h0000);
    op(OP_ACT, 2'h0, 14'h3FFF, 1'b0, 1'b0);
    op(OP_REF, 2'h0, ROW_ZERO, 1'b0, 1'b1);
    op(OP_SREF, 2'h0, ROW_ZERO, 1'b0, 1'b1);
    op(OP_PDN, 2'h0, ROW_ZERO, 1'b0, 1'b1);
    chk(16'(die_open), 16'h0001);
    op(OP_PRE, 2'h0, ROW_ZERO, 1'b1, 1'b0);
    chk(16'(die_open), 16'h0000);
    r0 = refresh_row;
    ar_seen = 1'b0;
    op(OP_REF, 2'h2, 14'h3FFF, 1'b0, 1'b0);
    chk(16'(ar_seen), 16'h0001);
    chk(16'(refresh_row), 16'(r0 + 14'h0001));
    chk(16'(die_open), 16'h0000);
    op(OP_WAKE, 2'h0, ROW_ZERO, 1'b0, 1'b1);
    op(OP_PDN, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    chk(16'({powered_down, rx_enabled}), 16'h0002);
    op(OP_ACT, 2'h2, ROW_ZERO, 1'b0, 1'b1);
    op(OP_WAKE, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    chk(16'({powered_down, rx_enabled}), 16'h0001);
    op(OP_SREF, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    chk(16'({self_refreshing, array_clk_en}), 16'h0002);
    stopped();
    op(OP_WAKE, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    chk(16'({self_refreshing, array_clk_en}), 16'h0001);
    op(OP_CSTOP, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    stopped();
    op(OP_WAKE, 2'h0, ROW_ZERO, 1'b0, 1'b0);
    op(OP_ACT, 2'h3, 14'h2AAA, 1'b0, 1'b0);
    chk(16'(die_open), 16'h0008);
    summarize();
  end
endmodule
`default_nettype wire
